// ---- logic/dqd_pkg.sv ----
// Constants and types shared by the dual quadrature decoder.
// Assumes a single 20 MHz clock and an 8-bit I/O register port.
package dqd_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h90;
    localparam logic [7:0] ADDR_CTRL   = 8'h91;
    localparam logic [7:0] ADDR_CNT1   = 8'h94;
    localparam logic [7:0] ADDR_CNT2   = 8'h96;

    // ------------------------------------------------------------
    // Field positions (channel c adds c * CH_FIELD_STRIDE)
    // ------------------------------------------------------------
    localparam int CH_FIELD_STRIDE = 4;
    localparam int ST_CLR_BIT      = 0;
    localparam int ST_DN_BIT       = 2;
    localparam int ST_UP_BIT       = 3;
    localparam int CTRL_SEL_LSB    = 2;
    localparam int SEL_ENABLE_BIT  = 1;
    localparam int SEL_UPPER_BIT   = 0;
    localparam int IRQ_LVL_LSB     = 0;

    // Port pins: Q on even bit, I on the odd bit above it
    localparam int PORT_CH_STRIDE    = 2;
    localparam int PORT_UPPER_OFFSET = 4;
    localparam int PORT_I_OFFSET     = 1;
    localparam int PORT_Q_OFFSET     = 0;

    // ------------------------------------------------------------
    // Reset and limit values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] CNT_RESET   = 8'h00;
    localparam logic [7:0] CNT_MAX     = 8'hFF;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [1:0] IRQ_OFF     = 2'h0;
    localparam int         NUM_CH      = 2;
    localparam int         PORT_W      = 8;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        STEP_NONE,
        STEP_UP,
        STEP_DOWN
    } dqd_step_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } dqd_io_req_s;

endpackage : dqd_pkg

// ---- logic/dqd_filter.sv ----
// One-bit input glitch filter for the quadrature decoder.
// Assumes tick is a one-cycle pulse already gated by clock enable.
`timescale 1ns/10ps
module dqd_filter
(
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic tick,
    input  wire logic raw,
    output logic      clean
);
    import dqd_pkg::*;

    logic sample;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    // two matching samples
    // A level must be seen on two ticks running to pass through
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sample <= 1'b0;
            clean  <= 1'b0;
        end
        else if (ce && tick)
        begin
            sample <= raw;
            if (raw == sample)
                clean <= raw;
        end
    end

endmodule : dqd_filter

// ---- logic/dqd_counter.sv ----
// Position counter of one decoder channel.
// Assumes filtered I/Q levels and a tick gated by clock enable.
`timescale 1ns/10ps
module dqd_counter
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       tick,
    input  wire logic [1:0] sel,
    input  wire logic       i_in,
    input  wire logic       q_in,
    input  wire logic       clear,
    output logic [7:0]      count,
    output logic            wrap_up,
    output logic            wrap_dn
);
    import dqd_pkg::*;

    logic [1:0] prev_iq;
    logic [1:0] last_sel;
    dqd_step_e  step;
    wire  [1:0] cur_iq = {i_in, q_in};
    wire        sel_en = sel[SEL_ENABLE_BIT];
    wire        resync = (sel != last_sel) || !sel_en;

    function automatic logic [1:0] fwd(input logic [1:0] s);
        case (s)
            2'h0:    fwd = 2'h1;
            2'h1:    fwd = 2'h3;
            2'h3:    fwd = 2'h2;
            default: fwd = 2'h0;
        endcase
    endfunction : fwd

    assign step = (!tick || resync || cur_iq == prev_iq) ? STEP_NONE :
                  (cur_iq == fwd(prev_iq))                ? STEP_UP   :
                  (prev_iq == fwd(cur_iq))                ? STEP_DOWN : STEP_NONE;

    assign wrap_up = (step == STEP_UP) && (count == CNT_MAX) && !clear;
    assign wrap_dn = (step == STEP_DOWN) && (count == CNT_RESET) && !clear;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            count    <= CNT_RESET;
            prev_iq  <= 2'h0;
            last_sel <= 2'h0;
        end
        else if (ce)
        begin
            last_sel <= sel;
            if (tick || resync)
                prev_iq <= cur_iq;
            if (clear)
                count <= CNT_RESET;
            else if (step == STEP_UP)
                count <= 8'(count + 8'h01);
            else if (step == STEP_DOWN)
                count <= 8'(count - 8'h01);
        end
    end

endmodule : dqd_counter

// ---- logic/dqd_top.sv ----
// Dual quadrature decoder: filters, two counters, status and control.
// Assumes a synchronous 8-bit I/O port, prescale tick and encoder pins.
//
// Contract
// - Two independent channels, each I and Q in, each an 8-bit counter.
// - Sampling, filtering and counting advance only on gated prescale ticks.
// - Each input filter rejects pulses shorter than one sample period.
// - Within the chosen nibble, I is the odd bit, Q the even bit.
// - Entering, leaving or changing input selection never steps a counter.
// - Interrupt raised on FFh to 00h or 00h to FFh only.
// - Wrap flags set with the interrupt; status read clears both, but a wrap in the read cycle keeps its flag set.
// - Status bit 7 is channel two up-wrap, bit 6 down-wrap.
// - Status bit 3 is channel one up-wrap, bit 2 down-wrap.
// - Status bits 5 and 1 always read zero.
// - Writing one to bit 4 or 0 clears that counter, no interrupt.
// - Control bits 7:6 select channel two inputs: off, bits 3:2, 7:6.
// - Control bits 3:2 select channel one inputs: off, bits 1:0, 5:4.
// - Control bits 5:4 have no effect on decoding.
// - Control bits 1:0: interrupt off, or priority level 1 to 3.
// - Count registers return their channel's current count.
// - After reset selections and interrupt level are zero.
`timescale 1ns/10ps
module dqd_top
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 prescale_timer_tick,
    input  wire logic [7:0]           port_in,
    input  wire dqd_pkg::dqd_io_req_s io_req,
    output logic [7:0]                io_rdata,
    output logic                      irq_req,
    output logic [1:0]                irq_level
);
    import dqd_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]        ctrl;
    logic              tick_prev;
    logic [NUM_CH-1:0] flag_up;
    logic [NUM_CH-1:0] flag_dn;
    logic [NUM_CH-1:0] next_flag_up;
    logic [NUM_CH-1:0] next_flag_dn;
    logic [NUM_CH-1:0] wrap_up;
    logic [NUM_CH-1:0] wrap_dn;
    logic [NUM_CH-1:0] clr_cnt;
    logic [NUM_CH-1:0] sel_en;
    logic [PORT_W-1:0] port_clean;
    logic [7:0]        count [NUM_CH];
    logic [7:0]        status_value;
    logic [7:0]        read_value;
    logic [7:0]        next_ctrl;

    // ------------------------------------------------------------
    // Tick gating
    // ------------------------------------------------------------
    // at most every other clock
    // Back-to-back ticks are thinned so sampling never beats half rate
    wire tick_ok = prescale_timer_tick && !tick_prev && ce;

    always_ff @(posedge clock)
    begin
        if (rst)
            tick_prev <= 1'b0;
        else if (ce)
            tick_prev <= tick_ok;
    end

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire hit_status = (io_req.addr == ADDR_STATUS);
    wire hit_ctrl   = (io_req.addr == ADDR_CTRL);
    wire hit_cnt1   = (io_req.addr == ADDR_CNT1);
    wire hit_cnt2   = (io_req.addr == ADDR_CNT2);
    wire wr_status  = ce && io_req.wr && hit_status;
    wire wr_ctrl    = ce && io_req.wr && hit_ctrl;
    wire rd_status  = ce && io_req.rd && hit_status;
    wire rd_any     = ce && io_req.rd;

    assign next_ctrl = wr_ctrl ? io_req.wdata : ctrl;

    always_comb
    begin
        status_value = 8'h00;
        for (int c = 0; c < NUM_CH; c++)
        begin
            status_value[ST_UP_BIT + c * CH_FIELD_STRIDE] = flag_up[c];
            status_value[ST_DN_BIT + c * CH_FIELD_STRIDE] = flag_dn[c];
        end
    end

    // count read back
    // Control is write-only; it and unmapped addresses read as zero
    assign read_value = hit_status ? status_value :
                        hit_cnt1   ? count[0]     :
                        hit_cnt2   ? count[1]     : 8'h00;

    // ------------------------------------------------------------
    // Input filters, one per port pin
    // ------------------------------------------------------------
    // Every pin is filtered all the time so a newly selected pair
    // arrives already settled and cannot fake a step
    genvar b;
    generate
        for (b = 0; b < PORT_W; b++)
        begin : g_filt
            dqd_filter u_filt
            (
                .clock (clock),
                .rst   (rst),
                .ce    (ce),
                .tick  (tick_ok),
                .raw   (port_in[b]),
                .clean (port_clean[b])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++)
        begin : g_ch
            localparam int SEL_LSB = CTRL_SEL_LSB + c * CH_FIELD_STRIDE;
            localparam int BASE_LO = c * PORT_CH_STRIDE;
            localparam int BASE_HI = BASE_LO + PORT_UPPER_OFFSET;
            wire [1:0] sel = ctrl[SEL_LSB +: 2];
            wire       upper = sel[SEL_UPPER_BIT];
            // odd bit is I, even is Q
            wire       i_pin = upper ? port_clean[BASE_HI + PORT_I_OFFSET]
                                     : port_clean[BASE_LO + PORT_I_OFFSET];
            wire       q_pin = upper ? port_clean[BASE_HI + PORT_Q_OFFSET]
                                     : port_clean[BASE_LO + PORT_Q_OFFSET];

            assign sel_en[c]  = sel[SEL_ENABLE_BIT];
            assign clr_cnt[c] = wr_status
                                && io_req.wdata[ST_CLR_BIT + c * CH_FIELD_STRIDE];

            dqd_counter u_cnt
            (
                .clock   (clock),
                .rst     (rst),
                .ce      (ce),
                .tick    (tick_ok),
                .sel     (sel),
                .i_in    (i_pin),
                .q_in    (q_pin),
                .clear   (clr_cnt[c]),
                .count   (count[c]),
                .wrap_up (wrap_up[c]),
                .wrap_dn (wrap_dn[c])
            );

            assign next_flag_up[c] = wrap_up[c] || (flag_up[c] && !rd_status);
            assign next_flag_dn[c] = wrap_dn[c] || (flag_dn[c] && !rd_status);
        end
    endgenerate

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // bits 5:4 stored, never decoded
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ctrl     <= CTRL_RESET;
            flag_up  <= '0;
            flag_dn  <= '0;
            io_rdata <= RDATA_RESET;
            irq_req  <= 1'b0;
        end
        else if (ce)
        begin
            ctrl    <= next_ctrl;
            flag_up <= next_flag_up;
            flag_dn <= next_flag_dn;
            irq_req <= (|{next_flag_up, next_flag_dn})
                       && (next_ctrl[IRQ_LVL_LSB +: 2] != IRQ_OFF);
            if (rd_any)
                io_rdata <= read_value;
        end
    end

    // Priority level comes straight from the control flops
    assign irq_level = ctrl[IRQ_LVL_LSB +: 2];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_reset_ctrl: assert property (
        $past(rst) |-> (ctrl[7:6] == 2'h0) && (ctrl[3:2] == 2'h0) && (irq_level == IRQ_OFF))
        else $error("control not cleared by reset");

    chk_tick_spacing: assert property (
        tick_ok |=> !tick_ok)
        else $error("decoder ticks on adjacent clocks");

    chk_tick_only: assert property (
        !tick_ok && !clr_cnt[0] |=> $stable(count[0]))
        else $error("channel one counted without a tick");

    chk_disabled_hold: assert property (
        ce && !sel_en[0] && !clr_cnt[0] |=> count[0] == $past(count[0]))
        else $error("disabled channel one moved");

    chk_select_change: assert property (
        wr_ctrl && (io_req.wdata[3:2] != ctrl[3:2]) && !clr_cnt[0]
        |=> ##1 count[0] == $past(count[0], 2))
        else $error("select change stepped channel one");

    chk_single_step: assert property (
        ce && !clr_cnt[1] |=> (count[1] == $past(count[1]))
            || (count[1] == 8'($past(count[1]) + 8'h01))
            || (count[1] == 8'($past(count[1]) - 8'h01)))
        else $error("channel two jumped more than one");

    chk_wrap_flag: assert property (
        $past(ce) && !$past(rst) && !$past(clr_cnt[0])
        && count[0] == CNT_RESET && $past(count[0]) == CNT_MAX |-> flag_up[0])
        else $error("up wrap did not set channel one flag");

    chk_flag_cause: assert property (
        ce && $rose(flag_dn[1]) |-> $past(wrap_dn[1]) && $past(count[1]) == CNT_RESET)
        else $error("channel two down flag without wrap");

    chk_irq_tie: assert property (
        irq_req == ((|{flag_up, flag_dn}) && irq_level != IRQ_OFF))
        else $error("interrupt and flags disagree");

    chk_read_clears: assert property (
        rd_status && !(|{wrap_up, wrap_dn}) |=> !(|{flag_up, flag_dn}) && !irq_req)
        else $error("status read left flags set");

    chk_set_wins: assert property (
        rd_status && wrap_up[1] |=> flag_up[1] && io_rdata[7] == $past(flag_up[1]))
        else $error("wrap lost against status read");

    chk_reserved_zero: assert property (
        rd_status |=> io_rdata[5] == 1'b0 && io_rdata[1] == 1'b0
            && io_rdata[4] == 1'b0 && io_rdata[0] == 1'b0)
        else $error("reserved status bits not zero");

    chk_count_read: assert property (
        rd_any && hit_cnt2 |=> io_rdata == $past(count[1]))
        else $error("count two readback wrong");

    chk_clear_count: assert property (
        clr_cnt[0] |=> count[0] == CNT_RESET && flag_up[0] == $past(flag_up[0] && !rd_status)
            && flag_dn[0] == $past(flag_dn[0] && !rd_status))
        else $error("clear failed or raised a flag");

    cov_wrap_up: cover property (wrap_up[0] ##1 flag_up[0]);
    cov_wrap_dn: cover property (wrap_dn[1] ##1 irq_req);
    cov_read_race: cover property (rd_status && (|{wrap_up, wrap_dn}));
    cov_clear: cover property (clr_cnt[1] && count[1] != CNT_RESET);

endmodule : dqd_top

// ---- test/dqd_encoder_model.sv ----
// Two incremental shaft encoders feeding the decoder's 8-bit input port.
// Assumes the bench calls move and glitch at a falling clock edge.
`timescale 1ns/10ps
module dqd_encoder_model
(
    input  wire logic       clock,
    input  wire logic [1:0] upper,
    output logic [7:0]      port
);
    logic [1:0] ph [2];
    logic [1:0] iq [2];
    logic [1:0] spare;

    initial
    begin
        ph    = '{2'h0, 2'h0};
        iq    = '{2'h0, 2'h0};
        spare = 2'h0;
    end

    // Unused pins float: a pattern never stable on two ticks
    always @(posedge clock)
        spare <= spare + 2'h1;

    // one pin per step, held hold clocks
    task automatic move(input int ch, input int up, input int hold);
        ph[ch] = (up != 0) ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
        iq[ch] = {ph[ch][1], ph[ch][1] ^ ph[ch][0]};
        repeat (hold) @(negedge clock);
    endtask : move

    // Short pulse on Q, seen by one tick at most
    task automatic glitch(input int ch);
        iq[ch][0] = ~iq[ch][0];
        repeat (2) @(negedge clock);
        iq[ch][0] = ~iq[ch][0];
    endtask : glitch

    always_comb
    begin
        port[1:0] = upper[0] ? spare : iq[0];
        port[5:4] = upper[0] ? iq[0] : spare;
        port[3:2] = upper[1] ? spare : iq[1];
        port[7:6] = upper[1] ? iq[1] : spare;
    end
endmodule : dqd_encoder_model

// ---- test/test_dual_quadrature_decoder.sv ----
// Self-checking bench for the dual quadrature decoder.
// Assumes a tick every 5 clocks; steps held 25 clocks settle the count.
`timescale 1ns/10ps
module test_dual_quadrature_decoder;
    import dqd_pkg::*;
    logic        clock;
    logic        rst;
    logic        ce;
    logic        prescale_timer_tick;
    logic        tick_on;
    logic [7:0]  port_in;
    logic [7:0]  io_rdata;
    logic        irq_req;
    logic [1:0]  irq_level;
    logic [1:0]  upper;
    dqd_io_req_s io_req;
    int          tick_div;
    int          errors;
    int          compares;

    dqd_top dqd_top_i
    (
        .clock               (clock),
        .rst                 (rst),
        .ce                  (ce),
        .prescale_timer_tick (prescale_timer_tick),
        .port_in             (port_in),
        .io_req              (io_req),
        .io_rdata            (io_rdata),
        .irq_req             (irq_req),
        .irq_level           (irq_level)
    );

    dqd_encoder_model dqd_encoder_model_i
    (
        .clock (clock),
        .upper (upper),
        .port  (port_in)
    );

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(negedge clock)
    begin
        tick_div = (tick_div == 4) ? 0 : tick_div + 1;
        prescale_timer_tick = tick_on && (tick_div == 0);
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        io_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clock);
        io_req.wr = 1'b0;
        // Idle cycle so back-to-back calls never re-raise a strobe at once
        @(negedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        io_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clock);
        io_req.rd = 1'b0;
        check(io_rdata, exp);
        @(negedge clock);
    endtask : rd

    task automatic steps(input int ch, input int up, input int n);
        repeat (n) dqd_encoder_model_i.move(ch, up, 25);
    endtask : steps

    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        $display("mismatch at %0t: timeout got %h expected %h", $time, 8'h00, 8'h01);
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        errors = 0;
        compares = 0;
        tick_div = 0;
        prescale_timer_tick = 1'b0;
        tick_on = 1'b1;
        rst = 1'b1;
        ce = 1'b1;
        upper = 2'b00;
        io_req = '0;
        repeat (6) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        rd(ADDR_STATUS, 8'h00);
        rd(ADDR_CNT1, 8'h00);
        rd(ADDR_CTRL, 8'h00);
        rd(8'h92, 8'h00);
        check({6'h00, irq_level}, 8'h00);
        for (int l = 0; l < 4; l++)
        begin
            wr(ADDR_CTRL, l[7:0]);
            check({6'h00, irq_level}, l[7:0]);
        end
        // Channel one on the lower pins, level 1
        wr(ADDR_CTRL, 8'h09);
        steps(0, 1, 3);
        rd(ADDR_CNT1, 8'h03);
        rd(ADDR_CNT2, 8'h00);
        dqd_encoder_model_i.glitch(0);
        repeat (25) @(negedge clock);
        rd(ADDR_CNT1, 8'h03);
        // No ticks, no counting
        tick_on = 1'b0;
        steps(0, 1, 1);
        rd(ADDR_CNT1, 8'h03);
        tick_on = 1'b1;
        repeat (25) @(negedge clock);
        rd(ADDR_CNT1, 8'h04);
        steps(0, 0, 4);
        check({7'h00, irq_req}, 8'h00);
        steps(0, 0, 1);
        check({7'h00, irq_req}, 8'h01);
        rd(ADDR_STATUS, 8'h04);
        check({7'h00, irq_req}, 8'h00);
        rd(ADDR_STATUS, 8'h00);
        steps(0, 1, 1);
        rd(ADDR_STATUS, 8'h08);
        // Counter clear through status writes
        steps(0, 1, 2);
        wr(ADDR_STATUS, 8'hEE);
        rd(ADDR_CNT1, 8'h02);
        wr(ADDR_STATUS, 8'h01);
        rd(ADDR_CNT1, 8'h00);
        check({7'h00, irq_req}, 8'h00);
        // Selection changes never step
        wr(ADDR_CTRL, 8'h05);
        steps(0, 1, 2);
        rd(ADDR_CNT1, 8'h00);
        wr(ADDR_CTRL, 8'h09);
        repeat (25) @(negedge clock);
        // Move pins only while disabled, so the new pair is settled
        wr(ADDR_CTRL, 8'h05);
        upper = 2'b01;
        repeat (25) @(negedge clock);
        wr(ADDR_CTRL, 8'h0D);
        repeat (25) @(negedge clock);
        rd(ADDR_CNT1, 8'h00);
        steps(0, 0, 1);
        rd(ADDR_CNT1, 8'hFF);
        rd(ADDR_STATUS, 8'h04);
        // Channel two upper, ignored bits set
        upper = 2'b11;
        repeat (25) @(negedge clock);
        wr(ADDR_CTRL, 8'hFD);
        repeat (25) @(negedge clock);
        rd(ADDR_CNT2, 8'h00);
        steps(1, 0, 1);
        rd(ADDR_CNT2, 8'hFF);
        rd(ADDR_STATUS, 8'h40);
        steps(1, 1, 1);
        rd(ADDR_STATUS, 8'h80);
        rd(ADDR_CNT1, 8'hFF);
        wr(ADDR_CTRL, 8'h3D);
        upper = 2'b01;
        repeat (25) @(negedge clock);
        wr(ADDR_CTRL, 8'hBD);
        repeat (25) @(negedge clock);
        steps(1, 1, 2);
        rd(ADDR_CNT2, 8'h02);
        wr(ADDR_CTRL, 8'h4D);
        steps(1, 1, 1);
        rd(ADDR_CNT2, 8'h02);
        // Level 00 masks the request, flags still set
        wr(ADDR_CTRL, 8'h8C);
        steps(1, 0, 3);
        check({7'h00, irq_req}, 8'h00);
        rd(ADDR_STATUS, 8'h40);
        wr(ADDR_STATUS, 8'h10);
        rd(ADDR_CNT2, 8'h00);
        wr(ADDR_CNT1, 8'h55);
        rd(ADDR_CNT1, 8'hFF);
        // Frozen while clock enable is low
        ce = 1'b0;
        wr(ADDR_STATUS, 8'h01);
        ce = 1'b1;
        rd(ADDR_CNT1, 8'hFF);
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        rd(ADDR_CNT1, 8'h00);
        check({6'h00, irq_level}, 8'h00);
        wrap_up();
    end
endmodule : test_dual_quadrature_decoder
